// ---- rffe_bus_master_model.sv ----
module rffe_bus_master_model #(
  parameter int HALF = 80
) (
  output logic sclk_o,
  output logic line_o,
  output logic drive_o,
  input wire logic line_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk_o = 1'b0;
    line_o = 1'b0;
    drive_o = 1'b1;
  end
  // Sends b[23] first; a 24-bit sequence is a read and frees b[9:1], sent on clocks 14..22
  task automatic seq(input logic [23:0] b, input int n, output logic [8:0] rd);
    rd = '0;
    #7;
    line_o = 1'b1;
    #(2 * HALF);
    line_o = 1'b0;
    #(4 * HALF);
    for (int k = 0; k < n; k++) begin
      sclk_o = 1'b1;
      drive_o = !(n == 24 && k > 13 && k < 23);
      line_o = b[23 - k];
      #HALF;
      if (!drive_o) begin
        rd = {rd[7:0], line_i};
      end
      sclk_o = 1'b0;
      #HALF;
    end
    drive_o = 1'b1;
    line_o = 1'b0;
  endtask : seq
endmodule : rffe_bus_master_model

// ---- rffe_switch_asserts.sv ----
module rffe_switch_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic sdata_o,
  input wire logic sdata_oe_n_o,
  input wire rffe_switch_pkg::throw_sel_t throw_sel_o,
  input wire logic isolation_o,
  input wire logic cmd_parity_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import rffe_switch_pkg::*;
  logic [5:0] drive_cnt;
  // Nine driven bits at 160 ns span 28 or 29 system cycles
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_cnt <= 6'h00;
    end else if (!sdata_oe_n_o) begin
      drive_cnt <= drive_cnt + 6'h01;
    end else begin
      drive_cnt <= 6'h00;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence quiet_s;
    $stable(throw_sel_o) && sdata_oe_n_o;
  endsequence
  sequence released_s;
    isolation_o && (throw_sel_o == '0) && sdata_oe_n_o;
  endsequence
  iso_match_a: assert property (isolation_o == (throw_sel_o == '0))
    else $error("isolation flag disagrees with throw select");
  one_throw_a: assert property ($onehot0(throw_sel_o))
    else $error("more than one throw selected");
  reset_state_a: assert property ($fell(rst_i) |-> released_s)
    else $error("outputs not in reset state");
  idle_low_a: assert property (sdata_oe_n_o |-> !sdata_o)
    else $error("data drive value high while released");
  err_pulse_a: assert property (cmd_parity_err_o |=> !cmd_parity_err_o)
    else $error("parity error flag longer than one cycle");
  err_quiet_a: assert property (cmd_parity_err_o |=> quiet_s [*8])
    else $error("command with bad parity had an effect");
  drive_len_a: assert property ($rose(sdata_oe_n_o) |-> drive_cnt inside {[27:30]})
    else $error("read drive window has wrong length");
  drive_max_a: assert property (drive_cnt <= 6'h1e)
    else $error("slave drives data line too long");
endmodule : rffe_switch_asserts

bind rffe_switch_path_slave rffe_switch_asserts i_asserts (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .sdata_i(sdata_i),
  .sdata_o(sdata_o), .sdata_oe_n_o(sdata_oe_n_o), .throw_sel_o(throw_sel_o),
  .isolation_o(isolation_o), .cmd_parity_err_o(cmd_parity_err_o)
);

// ---- rffe_switch_defs.svh ----
// Operation
// RULE1: Sequence starts with start condition, address leads.
// RULE2: Short write carries seven data bits directly.
// RULE3: Short write ends with parity and park.
// RULE4: Register write: type 10, five-bit address.
// RULE5: Write data byte, parity, park; store byte.
// RULE6: Register read: type 11, address, parity.
// RULE7: Read: park, slave sends byte, park.
// RULE8: Park cycles inserted where sequence marks them.
// RULE9: Bits 6:0 zero means isolation, also reset.
// RULE10: Codes 02 and 0a select throws 1, 2.
// RULE11: Codes 0e and 0b select throws 3, 4.
// RULE12: Codes 01 and 09 select throws 5, 6.
// RULE13: Codes 06 and 04 select throws 7, 8.
// RULE14: Codes 0c and 08 select throws 9, 10.
// RULE15: Switch register at address zero, eight bits.
// RULE16: Command parity error discards whole command.
// RULE17: Unlisted codes fall back to isolation.
// RULE18: Foreign slave address ignored, data line untouched.
`ifndef RFFE_SWITCH_DEFS_SVH
`define RFFE_SWITCH_DEFS_SVH
// Arbitrary slave identifier, change per board
`define SLAVE_ID_DEFAULT 4'h1
`define CMD_LAST_BIT 5'h0c
`define WDATA_LAST_BIT 5'h08
`define READ_LAST_BIT 5'h09
`define CNT_ZERO 5'h00
`define TYPE_WRITE 2'h2
`define TYPE_READ 2'h3
`define SWITCH_REG_ADDR 5'h00
`define SWITCH_REG_RESET 8'h00
`define CODE_THROW_1 7'h02
`define CODE_THROW_2 7'h0a
`define CODE_THROW_3 7'h0e
`define CODE_THROW_4 7'h0b
`define CODE_THROW_5 7'h01
`define CODE_THROW_6 7'h09
`define CODE_THROW_7 7'h06
`define CODE_THROW_8 7'h04
`define CODE_THROW_9 7'h0c
`define CODE_THROW_10 7'h08
`endif

// ---- rffe_switch_path_slave.sv ----
`include "rffe_switch_defs.svh"

module rffe_switch_path_slave #(
  parameter logic [3:0] SLAVE_ID = `SLAVE_ID_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  output logic sdata_o,
  output logic sdata_oe_n_o,
  output rffe_switch_pkg::throw_sel_t throw_sel_o,
  output logic isolation_o,
  output logic cmd_parity_err_o
);
  import rffe_switch_pkg::*;

  // Odd parity over a frame plus its parity bit
  function automatic logic odd_ok(input logic [12:0] bits);
    odd_ok = ^bits;
  endfunction : odd_ok

  function automatic throw_sel_t throw_decode(input logic [6:0] code);
    throw_sel_t sel;
    sel = '0;
    case (code)
      `CODE_THROW_1: sel.throw_port_1 = 1'b1; // [RULE10]
      `CODE_THROW_2: sel.throw_port_2 = 1'b1; // [RULE10]
      `CODE_THROW_3: sel.throw_port_3 = 1'b1; // [RULE11]
      `CODE_THROW_4: sel.throw_port_4 = 1'b1; // [RULE11]
      `CODE_THROW_5: sel.throw_port_5 = 1'b1; // [RULE12]
      `CODE_THROW_6: sel.throw_port_6 = 1'b1; // [RULE12]
      `CODE_THROW_7: sel.throw_port_7 = 1'b1; // [RULE13]
      `CODE_THROW_8: sel.throw_port_8 = 1'b1; // [RULE13]
      `CODE_THROW_9: sel.throw_port_9 = 1'b1; // [RULE14]
      `CODE_THROW_10: sel.throw_port_10 = 1'b1; // [RULE14]
      // All-zero and unlisted codes leave every throw open
      default: sel = '0; // [RULE9] [RULE17]
    endcase
    throw_decode = sel;
  endfunction : throw_decode

  // Link side, sampled on falling sclk edges

  link_state_t state;
  logic [4:0] cnt;
  logic [11:0] shreg;
  logic [4:0] cmd_addr;
  logic mine;
  logic [7:0] path_reg;
  logic wr_tog;
  logic perr_tog;
  logic ssc_used;
  logic ssc_meta_l;
  logic ssc_sync_l;

  // System side
  logic sclk_meta;
  logic sclk_s;
  logic sdata_meta;
  logic sdata_s;
  logic sdata_d;
  logic ssc_armed;
  logic ssc_tog;
  logic wr_meta;
  logic wr_s;
  logic wr_d;
  logic perr_meta;
  logic perr_s;
  logic perr_d;
  logic [7:0] path_sys;

  wire cmd_frame_t cmd_now = cmd_frame_t'(shreg);
  wire logic cmd_end = (state == ST_CMD) && (cnt == `CMD_LAST_BIT);
  wire logic cmd_par_ok = odd_ok({shreg, sdata_i});
  wire logic ssc_fresh = (ssc_sync_l != ssc_used);
  wire logic addr_match = (cmd_now.slave_addr == SLAVE_ID); // [RULE18]
  // A command counts only after a fresh start condition
  wire logic cmd_mine = addr_match && ssc_fresh && cmd_par_ok; // [RULE1] [RULE16]
  wire logic is_write = !cmd_now.short_wr && (cmd_now.kind == `TYPE_WRITE); // [RULE4]
  wire logic is_read = !cmd_now.short_wr && (cmd_now.kind == `TYPE_READ); // [RULE6]
  wire logic short_wr_go = cmd_end && cmd_mine && cmd_now.short_wr; // [RULE2]
  wire logic wdata_end = (state == ST_WDATA) && (cnt == `WDATA_LAST_BIT);
  wire logic wdata_par_ok = odd_ok({4'h0, shreg[7:0], sdata_i});
  wire logic wdata_go = wdata_end && mine && wdata_par_ok
                        && (cmd_addr == `SWITCH_REG_ADDR); // [RULE5] [RULE15]
  wire logic read_end = (state == ST_READ) && (cnt == `READ_LAST_BIT);
  wire logic perr_hit = cmd_end && addr_match && ssc_fresh && !cmd_par_ok;
  wire logic wr_hit = short_wr_go || wdata_go;

  // Short write clears bit 7, which has no path meaning
  wire logic [7:0] next_path = short_wr_go ? {1'b0, cmd_now[6:0]} :
                               wdata_go ? shreg[7:0] : path_reg; // [RULE2] [RULE5]

  // Frame lengths are walked even for foreign or corrupt commands
  wire link_state_t cmd_next = cmd_now.short_wr ? ST_PARK :
                               is_write ? ST_WDATA :
                               is_read ? ST_READ : ST_PARK; // [RULE3] [RULE8]
  wire link_state_t next_state = cmd_end ? cmd_next :
                                 wdata_end ? ST_PARK :
                                 read_end ? ST_PARK :
                                 (state == ST_PARK) ? ST_CMD : state; // [RULE7] [RULE8]
  wire logic cnt_clear = cmd_end || wdata_end || read_end || (state == ST_PARK);
  wire logic [4:0] next_cnt = cnt_clear ? `CNT_ZERO : cnt + 5'h01;

  // Read answer: data then odd parity, register addresses other than zero read as zero
  wire logic [7:0] rd_byte = (cmd_addr == `SWITCH_REG_ADDR) ? path_reg : `SWITCH_REG_RESET;
  wire logic [8:0] tx_word = {rd_byte, ~^rd_byte};
  wire logic drive_now = (state == ST_READ) && mine && (cnt != `CNT_ZERO); // [RULE7] [RULE18]
  wire logic [4:0] tx_idx = drive_now ? (`READ_LAST_BIT - cnt) : `CNT_ZERO;
  wire logic tx_bit = tx_word[tx_idx[3:0]];

  // Sequencer state. The link clock stands still between sequences,
  // so the first edge after a park belongs to the next command.
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_CMD;
    end else begin
      state <= next_state; // [RULE1]
    end
  end

  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= `CNT_ZERO;
    end else begin
      cnt <= next_cnt;
    end
  end

  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      shreg <= '0;
    end else begin
      shreg <= {shreg[10:0], sdata_i};
    end
  end

  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_addr <= `SWITCH_REG_ADDR;
      mine <= 1'b0;
    end else if (cmd_end) begin
      cmd_addr <= cmd_now.reg_addr;
      mine <= cmd_mine; // [RULE16] [RULE18]
    end
  end

  // Start condition is used up at the parity edge, valid command or not
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      ssc_used <= 1'b0;
    end else if (cmd_end) begin
      ssc_used <= ssc_sync_l;
    end
  end

  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      path_reg <= `SWITCH_REG_RESET; // [RULE9]
    end else begin
      path_reg <= next_path;
    end
  end

  // One toggle per event; events are a whole sequence apart
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_tog <= 1'b0;
    end else begin
      wr_tog <= wr_tog ^ wr_hit;
    end
  end

  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      perr_tog <= 1'b0;
    end else begin
      perr_tog <= perr_tog ^ perr_hit;
    end
  end

  // Start-condition toggle into the link domain
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      ssc_meta_l <= 1'b0;
      ssc_sync_l <= 1'b0;
    end else begin
      ssc_meta_l <= ssc_tog;
      ssc_sync_l <= ssc_meta_l;
    end
  end

  // Answer is launched on rising edges, half a period ahead of the master's sample
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      sdata_o <= 1'b0;
      sdata_oe_n_o <= 1'b1;
    end else begin
      sdata_o <= drive_now ? tx_bit : 1'b0; // [RULE7]
      sdata_oe_n_o <= !drive_now; // [RULE18]
    end
  end

  // System side: start-condition detection on synchronised pins.
  // Sclk is oversampled here only to see that it stays low.

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_meta <= 1'b0;
      sclk_s <= 1'b0;
    end else begin
      sclk_meta <= sclk_i;
      sclk_s <= sclk_meta;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdata_meta <= 1'b0;
      sdata_s <= 1'b0;
      sdata_d <= 1'b0;
    end else begin
      sdata_meta <= sdata_i;
      sdata_s <= sdata_meta;
      sdata_d <= sdata_s;
    end
  end

  wire logic sdata_rise = sdata_s && !sdata_d;
  wire logic sdata_fall = !sdata_s && sdata_d;
  wire logic ssc_seen = ssc_armed && sdata_fall && !sclk_s; // [RULE1]
  wire logic next_armed = sclk_s ? 1'b0 :
                          sdata_rise ? 1'b1 :
                          ssc_seen ? 1'b0 : ssc_armed;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ssc_armed <= 1'b0;
    end else begin
      ssc_armed <= next_armed;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ssc_tog <= 1'b0;
    end else begin
      ssc_tog <= ssc_tog ^ ssc_seen;
    end
  end

  // Event toggles back from the link domain
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_meta <= 1'b0;
      wr_s <= 1'b0;
      wr_d <= 1'b0;
    end else begin
      wr_meta <= wr_tog;
      wr_s <= wr_meta;
      wr_d <= wr_s;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      perr_meta <= 1'b0;
      perr_s <= 1'b0;
      perr_d <= 1'b0;
    end else begin
      perr_meta <= perr_tog;
      perr_s <= perr_meta;
      perr_d <= perr_s;
    end
  end

  wire logic wr_seen = wr_s ^ wr_d;
  wire logic perr_seen = perr_s ^ perr_d;
  // Link register has been stable for two sys edges when the toggle lands
  wire logic [7:0] next_path_sys = wr_seen ? path_reg : path_sys;
  wire throw_sel_t next_sel = throw_decode(path_sys[6:0]);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      path_sys <= `SWITCH_REG_RESET;
    end else begin
      path_sys <= next_path_sys;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      throw_sel_o <= '0; // [RULE9]
      isolation_o <= 1'b1;
      cmd_parity_err_o <= 1'b0;
    end else begin
      throw_sel_o <= next_sel; // [RULE17]
      isolation_o <= (next_sel == '0); // [RULE9]
      cmd_parity_err_o <= perr_seen; // [RULE16]
    end
  end

endmodule : rffe_switch_path_slave

// ---- rffe_switch_pkg.sv ----
package rffe_switch_pkg;
  typedef struct packed {
    logic throw_port_10;
    logic throw_port_9;
    logic throw_port_8;
    logic throw_port_7;
    logic throw_port_6;
    logic throw_port_5;
    logic throw_port_4;
    logic throw_port_3;
    logic throw_port_2;
    logic throw_port_1;
  } throw_sel_t;
  typedef struct packed {
    logic [3:0] slave_addr;
    logic short_wr;
    logic [1:0] kind;
    logic [4:0] reg_addr;
  } cmd_frame_t;
  typedef enum logic [1:0] {ST_CMD, ST_WDATA, ST_READ, ST_PARK} link_state_t;
endpackage : rffe_switch_pkg

// ---- tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rffe_switch_pkg::*;
  logic sys_clk_i = 1'b0;
  // Raised at time zero by the stimulus so that every async reset sees an edge
  logic rst_i = 1'b0;
  logic sclk, m_line, m_drive, sdata_w, sdata_o, oe_n, isolation_o, perr;
  throw_sel_t throw_sel_o;
  throw_sel_t exp_sel[$];
  logic [8:0] exp_rd[$];
  logic [8:0] got_rd;
  int got_n;
  int perr_n = 0;
  int exp_err[$];
  logic [7:0] d;
  logic [6:0] codes[10] = '{7'h02, 7'h0a, 7'h0e, 7'h0b, 7'h01, 7'h09, 7'h06, 7'h04, 7'h0c, 7'h08};
  logic [31:0] seed = 32'h00009b5f;
  int mismatches = 0;
  int samples_checked = 0;
  event done_ev;
  always #25 sys_clk_i = ~sys_clk_i;
  // Any level but low counts, so an unknown error pin cannot pass
  always @(negedge sys_clk_i) begin
    if (perr !== 1'b0) begin
      perr_n++;
    end
  end
  // Released line shows the inverse of the last master bit
  assign sdata_w = !oe_n ? sdata_o : (m_drive ? m_line : ~m_line);
  rffe_bus_master_model i_master (.sclk_o(sclk), .line_o(m_line), .drive_o(m_drive),
    .line_i(sdata_w));
  rffe_switch_path_slave i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk_i(sclk),
    .sdata_i(sdata_w), .sdata_o(sdata_o), .sdata_oe_n_o(oe_n), .throw_sel_o(throw_sel_o),
    .isolation_o(isolation_o), .cmd_parity_err_o(perr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [12:0] frame(input logic [3:0] sa, input logic [7:0] c);
    return {sa, c, ~^{sa, c}};
  endfunction : frame
  function automatic throw_sel_t dec(input logic [6:0] c);
    dec = '0;
    for (int i = 0; i < 10; i++) begin
      if (c == codes[i]) dec = throw_sel_t'(10'h001 << i);
    end
  endfunction : dec
  function automatic logic [23:0] sw(input logic [3:0] sa, input logic [6:0] v);
    return {frame(sa, {1'b1, v}), 1'b0, seed[9:0]};
  endfunction : sw
  function automatic logic [23:0] rw(input logic [4:0] a, input logic [7:0] v);
    return {frame(4'h1, {3'b010, a}), v, ~^v, 1'b0, seed[0]};
  endfunction : rw
  function automatic logic [23:0] rr(input logic [4:0] a);
    return {frame(4'h1, {3'b011, a}), 1'b0, seed[8:0], 1'b0};
  endfunction : rr
  task automatic chk_sel(input throw_sel_t e);
    samples_checked++;
    if (throw_sel_o !== e || isolation_o !== (e == '0)) begin
      mismatches++;
      $display("unexpected throw_sel_o expected %h seen %h", e, throw_sel_o);
    end
  endtask : chk_sel
  task automatic chk_rd(input logic [8:0] e);
    samples_checked++;
    if (got_rd !== e) begin
      mismatches++;
      $display("unexpected read_data expected %h seen %h", e, got_rd);
    end
  endtask : chk_rd
  task automatic chk_err(input int e);
    samples_checked++;
    if (perr_n != e) begin
      mismatches++;
      $display("unexpected cmd_parity_err_o expected %0d seen %0d", e, perr_n);
    end
    perr_n = 0;
  endtask : chk_err
  always @(done_ev) begin
    chk_sel(exp_sel.pop_front());
    chk_err(exp_err.pop_front());
    if (got_n == 24) chk_rd(exp_rd.pop_front());
  end
  task automatic go(input logic [23:0] b, input int n, input throw_sel_t es,
      input logic [8:0] er, input int ee = 0);
    logic [8:0] rd;
    exp_sel.push_back(es);
    exp_err.push_back(ee);
    if (n == 24) exp_rd.push_back(er);
    i_master.seq(b, n, rd);
    got_rd = rd;
    got_n = n;
    void'(rnd());
    repeat (8) @(posedge sys_clk_i);
    -> done_ev;
  endtask : go
  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    mismatches++;
    end_of_test();
  end
  initial begin
    rst_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    got_n = 0;
    exp_sel.push_back('0);
    exp_err.push_back(0);
    -> done_ev;
    for (int i = 0; i < 10; i++) begin
      go(sw(4'h1, codes[i]), 14, dec(codes[i]), 9'h000);
    end
    go(sw(4'h1, 7'h00), 14, '0, 9'h000);
    go(sw(4'h1, codes[0]), 14, dec(codes[0]), 9'h000);
    go(sw(4'h1, 7'h7f), 14, '0, 9'h000);
    go(sw(4'h1, codes[3]) ^ 24'h000800, 14, '0, 9'h000, 1);
    go(sw(4'h2, codes[3]), 14, '0, 9'h000);
    for (int i = 0; i < 3; i++) begin
      d = 8'(rnd());
      go(rw(5'h00, d), 23, dec(d[6:0]), 9'h000);
      go(rr(5'h00), 24, dec(d[6:0]), {d, ~^d});
    end
    // Foreign read: undriven line shows the inverted master bits
    go(rr(5'h00) ^ 24'h300000, 24, dec(d[6:0]), ~seed[8:0]);
    go(rw(5'h01, 8'h02), 23, dec(d[6:0]), 9'h000);
    go(rr(5'h01), 24, dec(d[6:0]), 9'h001);
    // Let the checker take the last note before the verdict
    repeat (2) @(posedge sys_clk_i);
    end_of_test();
  end
endmodule : tb_top
